// file: hw/wdpd_pkg.sv
package wdpd_pkg;
	// ----------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_WDOG_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RST_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_SYS_CLK_CTRL = 8'h08;
	localparam logic [7:0] ADDR_PA_WAKE_EN = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CMD = 8'h14;
	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam logic [7:0] WDOG_CTRL_RST = 8'h53;
	localparam logic [4:0] KEY_ENABLE = 5'h0a;
	localparam logic [4:0] KEY_DISABLE = 5'h15;
	localparam int KEY_LSB = 3;
	localparam int CMD_HALT_BIT = 0;
	localparam int CMD_CLRWDT_BIT = 1;
	localparam int STAT_PDF_BIT = 0;
	localparam int STAT_TO_BIT = 1;
	localparam int SCC_FAST_BIT = 1;
	localparam int SCC_SLOW_BIT = 0;
	// Soft-reset delay in slow RC clock cycles
	localparam int SRESET_CYCLES = 16;
	localparam int CNT_W = 18;

	typedef enum logic [1:0] {
		WDPD_RUN = 2'b00,
		WDPD_HALTED = 2'b01,
		WDPD_KEYWAIT = 2'b10
	} wdpd_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} wdpd_apb_req_t;

	typedef struct packed {
		wdpd_mode_t mode;
		logic [7:0] watchdog_control;
		logic [1:0] system_clock_ctrl;
		logic [7:0] pa_wake_en;
		logic [7:0] pa_prev;
		logic power_down_flag;
		logic to;
		logic key_fault;
		logic [CNT_W-1:0] cnt;
		logic [7:0] sreset_cnt;
		logic irq_prev;
		logic lirc_prev;
		logic [31:0] prdata;
		logic fast_on;
		logic sub_on;
		logic cpu_stop;
		logic rst_pulse;
		logic pcsp_rst;
		logic irq_service;
		logic resume;
	} wdpd_state_t;
endpackage

// file: hw/wdpd_top.sv
`timescale 1ns/1ps
// Contract
// - Halt with both keep bits: both clocks on
// - Halt fast-only keep: fast on, sub off
// - Halt leaves memory, registers, ports unchanged
// - Halt sets power-down, clears time-out flag
// - Halt clears counter; counts only if enabled
// - Wake on port edge, interrupt, overflow
// - Power-down flag cleared by power-up or clear
// - Overflow wake: time-out set, PC/SP reset
// - Per-pin port A wake enable, resume after
// - Disabled or stack-full interrupt: resume, pending
// - Enabled interrupt, stack free: normal response
// - Interrupt pending before halt cannot wake
// - Divider 2^8..2^18 chosen by period field
// - Key enables, disables, else delayed reset
// - Invalid key sets key-fault flag
// - Key-fault flag cleared only by software
// - Overflow when running resets, sets time-out
// - Power-on key enabled, period field 011
// - Reset-flag upper nibble reads zero
// - Invalid key write, clear, halt clear counter
module wdpd_top #(
	parameter int SRESET_CYCLES = wdpd_pkg::SRESET_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Core events
	input wire logic i_lirc_clk,
	input wire logic [7:0] i_port_a,
	input wire logic i_irq_req,
	input wire logic i_irq_enabled,
	input wire logic i_stack_full,
	// Power and reset outputs
	output logic o_fast_osc_on,
	output logic o_sub_clk_on,
	output logic o_cpu_stop,
	output logic o_device_reset,
	output logic o_pc_sp_reset,
	output logic o_irq_service,
	output logic o_resume_after_halt
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	// Three modes: running, halted (one of the idle or sleep variants as
	// chosen by the keep bits) and waiting out the soft-reset delay after a
	// bad key. Everything that must survive a halt lives in one struct, so a
	// halt touches only the fields named in the halt branch and nothing else.
	// Port levels, interrupt level and slow clock level are remembered one
	// cycle back to find edges.
	wdpd_pkg::wdpd_state_t state_ff;
	wdpd_pkg::wdpd_state_t nxt_state;
	wdpd_pkg::wdpd_apb_req_t req;
	logic wr;
	logic rd;
	logic mapped;
	logic halt_cmd;
	logic clr_cmd;
	logic lirc_rise;
	logic wd_enabled;
	logic overflow;
	logic [4:0] key;
	logic key_bad;
	logic [7:0] pa_fall;
	logic irq_new;
	localparam int CNT_W_L = wdpd_pkg::CNT_W;
	localparam int PINS = 8;
	logic [CNT_W_L-1:0] limit;
	logic [CNT_W_L-1:0] cnt_top;
	logic [4:0] wr_key;
	logic wr_key_bad;
	logic wake_port;
	logic wake_ovf;
	logic wake_irq;
	logic wake_any;
	logic irq_direct;
	logic [7:0] sreset_next;
	logic fault_due;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
		paddr: i_paddr, pwdata: i_pwdata};
	assign wr = req.psel && req.penable && req.pwrite;
	assign rd = req.psel && req.penable && !req.pwrite;
	assign mapped = (req.paddr == wdpd_pkg::ADDR_WDOG_CTRL) || (req.paddr == wdpd_pkg::ADDR_RST_FLAGS)
		|| (req.paddr == wdpd_pkg::ADDR_SYS_CLK_CTRL) || (req.paddr == wdpd_pkg::ADDR_PA_WAKE_EN)
		|| (req.paddr == wdpd_pkg::ADDR_STATUS) || (req.paddr == wdpd_pkg::ADDR_CMD);
	assign halt_cmd = wr && req.paddr == wdpd_pkg::ADDR_CMD && req.pwdata[wdpd_pkg::CMD_HALT_BIT];
	assign clr_cmd = wr && req.paddr == wdpd_pkg::ADDR_CMD && req.pwdata[wdpd_pkg::CMD_CLRWDT_BIT];
	assign key = state_ff.watchdog_control[7:wdpd_pkg::KEY_LSB];
	assign key_bad = (key != wdpd_pkg::KEY_ENABLE) && (key != wdpd_pkg::KEY_DISABLE);
	assign wd_enabled = (key == wdpd_pkg::KEY_ENABLE);

	// ----------------------------------------
	// Key write check
	// ----------------------------------------
	// A written key outside both codes restarts the count at once
	assign wr_key = req.pwdata[7:wdpd_pkg::KEY_LSB];
	assign wr_key_bad = (wr_key != wdpd_pkg::KEY_ENABLE) && (wr_key != wdpd_pkg::KEY_DISABLE);

	// ----------------------------------------
	// Event edges
	// ----------------------------------------
	// Slow clock is oversampled; its edge steps the counter
	assign lirc_rise = i_lirc_clk && !state_ff.lirc_prev;
	// Only a fresh request edge wakes; one already high at halt is ignored
	assign irq_new = i_irq_req && !state_ff.irq_prev;

	// ----------------------------------------
	// Port A wake edges
	// ----------------------------------------
	// Each pin has its own enable; a disabled pin may toggle freely
	// without disturbing a halted core.
	for (genvar g = 0; g < PINS; g++)
	begin : pin_g
		assign pa_fall[g] = state_ff.pa_prev[g] && !i_port_a[g] && state_ff.pa_wake_en[g];
	end

	// ----------------------------------------
	// Wake sources
	// ----------------------------------------
	// Overflow outranks the other sources: it must reset PC and stack
	// even when a pin edge or interrupt lands in the same cycle.
	// A serviced interrupt needs it enabled and a free stack level.
	assign wake_port = |pa_fall;
	assign wake_ovf = overflow;
	assign wake_irq = irq_new;
	assign wake_any = wake_ovf || wake_port || wake_irq;
	assign irq_direct = wake_irq && i_irq_enabled && !i_stack_full;

	// ----------------------------------------
	// Soft-reset delay
	// ----------------------------------------
	// Counted in slow clock rises so the delay tracks the RC clock,
	// not the bus clock.
	assign sreset_next = state_ff.sreset_cnt + 8'h01;
	assign fault_due = lirc_rise && (32'(sreset_next) >= SRESET_CYCLES);

	// ----------------------------------------
	// Period select
	// ----------------------------------------
	always_comb
	begin
		unique case (state_ff.watchdog_control[2:0])
			3'h0: limit = CNT_W_L'(1) << 8;
			3'h1: limit = CNT_W_L'(1) << 10;
			3'h2: limit = CNT_W_L'(1) << 12;
			3'h3: limit = CNT_W_L'(1) << 14;
			3'h4: limit = CNT_W_L'(1) << 15;
			3'h5: limit = CNT_W_L'(1) << 16;
			3'h6: limit = CNT_W_L'(1) << 17;
			3'h7: limit = '0;
		endcase
	end
	// 2^18 wraps the 18-bit counter to zero, so limit 0 means full range
	// The last count before the ratio is the overflow point; a disabled
	// watchdog never overflows even if the counter holds that value.
	assign cnt_top = limit - CNT_W_L'(1);
	assign overflow = wd_enabled && lirc_rise && (state_ff.cnt == cnt_top);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.lirc_prev = i_lirc_clk;
		nxt_state.pa_prev = i_port_a;
		nxt_state.irq_prev = i_irq_req;
		nxt_state.rst_pulse = 1'b0;
		nxt_state.pcsp_rst = 1'b0;
		nxt_state.irq_service = 1'b0;
		nxt_state.resume = 1'b0;
		nxt_state.prdata = '0;

		// --------------------------------
		// Bus reads
		// --------------------------------
		if (rd)
		begin
			unique case (req.paddr)
				wdpd_pkg::ADDR_WDOG_CTRL: nxt_state.prdata = {24'h0, state_ff.watchdog_control};
				wdpd_pkg::ADDR_RST_FLAGS: nxt_state.prdata = {28'h0, 3'h0, state_ff.key_fault};
				wdpd_pkg::ADDR_SYS_CLK_CTRL: nxt_state.prdata = {30'h0, state_ff.system_clock_ctrl};
				wdpd_pkg::ADDR_PA_WAKE_EN: nxt_state.prdata = {24'h0, state_ff.pa_wake_en};
				wdpd_pkg::ADDR_STATUS: nxt_state.prdata = {30'h0, state_ff.to, state_ff.power_down_flag};
				default: nxt_state.prdata = '0;
			endcase
		end
		// Counter steps on slow clock while enabled
		if (wd_enabled && lirc_rise)
			nxt_state.cnt = state_ff.cnt + CNT_W_L'(1);

		// --------------------------------
		// Register writes
		// --------------------------------
		if (wr)
		begin
			unique case (req.paddr)
				wdpd_pkg::ADDR_WDOG_CTRL:
				begin
					nxt_state.watchdog_control = req.pwdata[7:0];
					if (wr_key_bad)
						nxt_state.cnt = '0;
				end
				wdpd_pkg::ADDR_SYS_CLK_CTRL: nxt_state.system_clock_ctrl = req.pwdata[1:0];
				wdpd_pkg::ADDR_PA_WAKE_EN: nxt_state.pa_wake_en = req.pwdata[7:0];
				// Writing zero clears the fault flag; ones are ignored
				wdpd_pkg::ADDR_RST_FLAGS:
					if (!req.pwdata[0])
						nxt_state.key_fault = 1'b0;
				default: ;
			endcase
		end
		if (clr_cmd && state_ff.mode == wdpd_pkg::WDPD_RUN)
		begin
			nxt_state.cnt = '0;
			nxt_state.power_down_flag = 1'b0;
		end

		// --------------------------------
		// Mode sequencing
		// --------------------------------
		// Sets below come after the writes above, so a flag set by
		// hardware wins over a software clear in the same cycle.
		unique case (state_ff.mode)
			wdpd_pkg::WDPD_RUN:
			begin
				if (key_bad)
				begin
					nxt_state.key_fault = 1'b1;
					nxt_state.sreset_cnt = '0;
					nxt_state.mode = wdpd_pkg::WDPD_KEYWAIT;
				end
				else if (overflow)
				begin
					nxt_state.rst_pulse = 1'b1;
					nxt_state.to = 1'b1;
					nxt_state.cnt = '0;
				end
				else if (halt_cmd)
				begin
					// Power controls, flags and counter change; memory and ports are left alone
					nxt_state.mode = wdpd_pkg::WDPD_HALTED;
					nxt_state.cpu_stop = 1'b1;
					nxt_state.fast_on = state_ff.system_clock_ctrl[wdpd_pkg::SCC_FAST_BIT];
					nxt_state.sub_on = state_ff.system_clock_ctrl[wdpd_pkg::SCC_SLOW_BIT];
					nxt_state.power_down_flag = 1'b1;
					nxt_state.to = 1'b0;
					nxt_state.cnt = '0;
				end
			end
			wdpd_pkg::WDPD_HALTED:
			begin
				if (key_bad)
				begin
					nxt_state.key_fault = 1'b1;
					nxt_state.sreset_cnt = '0;
					nxt_state.mode = wdpd_pkg::WDPD_KEYWAIT;
				end
				else if (wake_any)
				begin
					// Every wake brings both clocks back in the same cycle the core runs again
					nxt_state.mode = wdpd_pkg::WDPD_RUN;
					nxt_state.cpu_stop = 1'b0;
					nxt_state.fast_on = 1'b1;
					nxt_state.sub_on = 1'b1;
					if (wake_ovf)
					begin
						nxt_state.to = 1'b1;
						nxt_state.pcsp_rst = 1'b1;
						nxt_state.cnt = '0;
					end
					else if (irq_direct)
						nxt_state.irq_service = 1'b1;
					else
						nxt_state.resume = 1'b1;
				end
			end
			wdpd_pkg::WDPD_KEYWAIT:
			begin
				// Halt and clear commands are ignored here; only the delay runs
				if (lirc_rise)
					nxt_state.sreset_cnt = sreset_next;
				if (fault_due)
				begin
					// Key fault is a full reset: control goes back to power-on values
					nxt_state.rst_pulse = 1'b1;
					nxt_state.watchdog_control = wdpd_pkg::WDOG_CTRL_RST;
					nxt_state.cnt = '0;
					nxt_state.mode = wdpd_pkg::WDPD_RUN;
					nxt_state.cpu_stop = 1'b0;
					nxt_state.fast_on = 1'b1;
					nxt_state.sub_on = 1'b1;
				end
			end
			default: nxt_state.mode = wdpd_pkg::WDPD_RUN;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			// Power-on values: running, both clocks on, watchdog enabled
			state_ff.mode <= wdpd_pkg::WDPD_RUN;
			state_ff.watchdog_control <= wdpd_pkg::WDOG_CTRL_RST;
			state_ff.system_clock_ctrl <= 2'h0;
			state_ff.pa_wake_en <= 8'h00;
			// Pins idle high, so no false falling edge follows reset
			state_ff.pa_prev <= 8'hff;
			state_ff.power_down_flag <= 1'b0;
			state_ff.to <= 1'b0;
			state_ff.key_fault <= 1'b0;
			state_ff.cnt <= '0;
			state_ff.sreset_cnt <= 8'h00;
			state_ff.irq_prev <= 1'b0;
			state_ff.lirc_prev <= 1'b0;
			state_ff.prdata <= 32'h0;
			state_ff.fast_on <= 1'b1;
			state_ff.sub_on <= 1'b1;
			state_ff.cpu_stop <= 1'b0;
			state_ff.rst_pulse <= 1'b0;
			state_ff.pcsp_rst <= 1'b0;
			state_ff.irq_service <= 1'b0;
			state_ff.resume <= 1'b0;
		end
		else
			state_ff <= nxt_state;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Register bus: zero wait states, read data one cycle after access
	assign o_prdata = state_ff.prdata;
	assign o_pready = 1'b1;
	assign o_pslverr = req.psel && req.penable && !mapped;

	// Power control
	assign o_fast_osc_on = state_ff.fast_on;
	assign o_sub_clk_on = state_ff.sub_on;
	assign o_cpu_stop = state_ff.cpu_stop;

	// Wake and reset pulses, one cycle each
	assign o_device_reset = state_ff.rst_pulse;
	assign o_pc_sp_reset = state_ff.pcsp_rst;
	assign o_irq_service = state_ff.irq_service;
	assign o_resume_after_halt = state_ff.resume;
endmodule

// file: sim/test_watchdog_power_down_wake.sv
`timescale 1ns/1ps
module test_watchdog_power_down_wake;
	logic i_clk, i_rst, i_psel, i_penable, i_pwrite;
	logic i_lirc_clk = 1'b0;
	logic rv = 1'b0;
	logic i_irq_req, i_irq_enabled, i_stack_full;
	logic [7:0] i_paddr, i_port_a;
	logic [31:0] i_pwdata, o_prdata;
	logic o_pready, o_pslverr, o_fast_osc_on, o_sub_clk_on, o_cpu_stop;
	logic o_device_reset, o_pc_sp_reset, o_irq_service, o_resume_after_halt;
	logic [3:0] ev;
	logic [2:0] lc = 3'h0;
	logic [31:0] exq[$];
	int err_total = 0;
	int checks = 0;
	int m, n, p;
	// Short soft-reset delay keeps the key-fault wait small
	wdpd_top #(.SRESET_CYCLES(2)) wdpd_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_lirc_clk(i_lirc_clk), .i_port_a(i_port_a), .i_irq_req(i_irq_req),
		.i_irq_enabled(i_irq_enabled), .i_stack_full(i_stack_full),
		.o_fast_osc_on(o_fast_osc_on), .o_sub_clk_on(o_sub_clk_on), .o_cpu_stop(o_cpu_stop),
		.o_device_reset(o_device_reset), .o_pc_sp_reset(o_pc_sp_reset),
		.o_irq_service(o_irq_service), .o_resume_after_halt(o_resume_after_halt));
	assign ev = {o_device_reset, o_pc_sp_reset, o_irq_service, o_resume_after_halt};
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		checks++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge i_clk);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		do
			@(posedge i_clk);
		while (o_pready !== 1'b1 && ++k < 20);
		if (k >= 20)
		begin
			err_total++;
			print_verdict();
		end
		chk(32'(o_pslverr), 32'(a > wdpd_pkg::ADDR_CMD || a[1:0] != 2'h0), "pslverr");
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// Waits for one wake or reset pulse; a bound that runs out ends the run
	task automatic wt(input int w, input int lim);
		n = 0;
		do
		begin
			@(negedge i_clk);
			n++;
			if (n > lim)
			begin
				err_total++;
				print_verdict();
			end
		end
		while (ev[w] !== 1'b1);
	endtask
	task automatic pwake();
		@(posedge i_clk) i_port_a <= 8'h00;
		wt(0, 50);
		@(posedge i_clk) i_port_a <= 8'hff;
	endtask
	always @(posedge i_clk)
	begin
		if (rv)
			chk(o_prdata, exq.pop_front(), "prdata");
		rv <= i_psel && i_penable && !i_pwrite;
		lc <= lc + 3'h1;
		i_lirc_clk <= lc[2];
	end
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial
	begin
		{i_psel, i_penable, i_pwrite, i_irq_req, i_stack_full} = '0;
		{i_irq_enabled, i_rst, i_paddr, i_pwdata, i_port_a} = {2'b11, 40'h0, 8'hff};
		p = $urandom(83650);
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		// --------------------------------
		// Reset values and halt modes
		// --------------------------------
		rd(wdpd_pkg::ADDR_WDOG_CTRL, 32'h53);
		rd(wdpd_pkg::ADDR_RST_FLAGS, 32'h0);
		rd(8'h3c, 32'h0);
		for (m = 0; m < 4; m++)
		begin
			p = $urandom % 8;
			apb(1'b1, wdpd_pkg::ADDR_PA_WAKE_EN, 32'(8'h01 << p));
			apb(1'b1, wdpd_pkg::ADDR_SYS_CLK_CTRL, 32'(m));
			apb(1'b1, wdpd_pkg::ADDR_CMD, 32'h1);
			repeat (2) @(negedge i_clk);
			chk(32'({o_cpu_stop, o_fast_osc_on, o_sub_clk_on}), 32'(m + 4), "halt");
			rd(wdpd_pkg::ADDR_STATUS, 32'h1);
			rd(wdpd_pkg::ADDR_WDOG_CTRL, 32'h53);
			@(posedge i_clk) i_port_a <= ~(8'h01 << ((p + 1) % 8));
			repeat (8) @(negedge i_clk);
			chk(32'(o_cpu_stop), 32'h1, "masked pin");
			pwake();
		end
		apb(1'b1, wdpd_pkg::ADDR_CMD, 32'h2);
		rd(wdpd_pkg::ADDR_STATUS, 32'h0);
		$display("halt and port wake test done");
		for (m = 0; m < 2; m++)
		begin
			@(posedge i_clk) i_irq_enabled <= m[0];
			apb(1'b1, wdpd_pkg::ADDR_CMD, 32'h1);
			@(posedge i_clk) i_irq_req <= 1'b1;
			wt(m, 50);
			@(posedge i_clk) i_irq_req <= 1'b0;
		end
		@(posedge i_clk) i_irq_req <= 1'b1;
		apb(1'b1, wdpd_pkg::ADDR_CMD, 32'h1);
		repeat (20) @(negedge i_clk);
		chk(32'(o_cpu_stop), 32'h1, "pending irq");
		pwake();
		i_irq_req <= 1'b0;
		$display("interrupt wake test done");
		// --------------------------------
		// Watchdog period, disable, overflow and key fault
		// --------------------------------
		apb(1'b1, wdpd_pkg::ADDR_WDOG_CTRL, 32'ha8);
		apb(1'b1, wdpd_pkg::ADDR_CMD, 32'h1);
		repeat (2500) @(negedge i_clk);
		chk(32'(o_cpu_stop), 32'h1, "disabled");
		pwake();
		apb(1'b1, wdpd_pkg::ADDR_WDOG_CTRL, 32'h50);
		apb(1'b1, wdpd_pkg::ADDR_CMD, 32'h1);
		wt(2, 4000);
		chk(32'(n > 2000 && n < 2100), 32'h1, "period");
		rd(wdpd_pkg::ADDR_STATUS, 32'h3);
		wt(3, 4000);
		apb(1'b1, wdpd_pkg::ADDR_WDOG_CTRL, 32'hf8);
		wt(3, 200);
		rd(wdpd_pkg::ADDR_RST_FLAGS, 32'h1);
		rd(wdpd_pkg::ADDR_WDOG_CTRL, 32'h53);
		apb(1'b1, wdpd_pkg::ADDR_RST_FLAGS, 32'h0);
		rd(wdpd_pkg::ADDR_RST_FLAGS, 32'h0);
		@(posedge i_clk);
		$display("watchdog test done");
		print_verdict();
	end
endmodule

// file: sim/wdpd_monitor.sv
`timescale 1ns/1ps
module wdpd_monitor (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register bus
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pslverr,
	// Core side
	input wire logic i_irq_req,
	input wire logic i_irq_enabled,
	input wire logic i_stack_full,
	input wire logic o_fast_osc_on,
	input wire logic o_sub_clk_on,
	input wire logic o_cpu_stop,
	input wire logic o_device_reset,
	input wire logic o_pc_sp_reset,
	input wire logic o_irq_service,
	input wire logic o_resume_after_halt
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	sequence acc_s;
		i_psel && i_penable;
	endsequence
	sequence halt_s;
		acc_s ##0 i_pwrite && i_paddr == wdpd_pkg::ADDR_CMD && i_pwdata[0] && !o_cpu_stop;
	endsequence
	sequence irq_s;
		$rose(i_irq_req) && o_cpu_stop && !o_resume_after_halt;
	endsequence
	halt_stop_a: assert property (halt_s |-> ##[1:2] o_cpu_stop)
		else $error("halt did not stop");
	run_clocks_a: assert property (!$past(o_cpu_stop) && !o_cpu_stop |-> o_fast_osc_on && o_sub_clk_on)
		else $error("clock off while running");
	wake_cause_a: assert property ($fell(o_cpu_stop) |-> |{o_resume_after_halt, o_irq_service, o_pc_sp_reset, o_device_reset})
		else $error("wake without cause");
	resume_wake_a: assert property (o_resume_after_halt |-> $past(o_cpu_stop) && !o_cpu_stop)
		else $error("resume outside halt");
	irq_serve_a: assert property (irq_s ##0 i_irq_enabled && !i_stack_full |-> ##[0:2] o_irq_service)
		else $error("no interrupt response");
	irq_masked_a: assert property (irq_s ##0 !i_irq_enabled |-> ##[0:2] o_resume_after_halt)
		else $error("no resume on masked wake");
	ovf_wake_a: assert property (o_pc_sp_reset |-> $past(o_cpu_stop) && !o_device_reset)
		else $error("overflow wake outside halt");
	reset_pulse_a: assert property (o_device_reset |=> !o_device_reset)
		else $error("device reset too long");
	unmapped_err_a: assert property (acc_s ##0 i_paddr > 8'h14 |-> o_pslverr)
		else $error("no error on unmapped");
endmodule
bind wdpd_top wdpd_monitor wdpd_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_pslverr(o_pslverr), .i_irq_req(i_irq_req), .i_irq_enabled(i_irq_enabled),
	.i_stack_full(i_stack_full), .o_fast_osc_on(o_fast_osc_on), .o_sub_clk_on(o_sub_clk_on),
	.o_cpu_stop(o_cpu_stop), .o_device_reset(o_device_reset), .o_pc_sp_reset(o_pc_sp_reset),
	.o_irq_service(o_irq_service), .o_resume_after_halt(o_resume_after_halt));
